//--- rtl/iep_input_event_processor.v
// Per-channel debounce, edge selection, pulse counting, time stamp and event counting.
`timescale 1ns/1ps
`default_nettype none
`include "iep_consts.vh"

module iep_input_event_processor #(
	parameter MS_CYCLES = `IEP_MS_NS / `IEP_CLK_NS
) (
	input  wire                ref_clk,
	input  wire                rst,
	input  wire [63:0]         chanIn,
	input  wire                testMode,
	input  wire                stampIrqEn,
	input  wire                countIrqEn,
	input  wire [`IEP_AW-1:0]  hostAddr,
	input  wire [`IEP_DW-1:0]  hostWrData,
	input  wire                hostWrEn,
	input  wire                hostRdEn,
	output reg  [`IEP_DW-1:0]  hostRdData_ff,
	output reg                 hostRdValid_ff,
	output reg  [63:0]         chanLevel_ff,
	output reg  [63:0]         cosStrobe_ff,
	output reg                 evtValid_ff,
	output reg  [`IEP_DW-1:0]  evtStamp_ff,
	output reg  [`IEP_DW-1:0]  evtInfo_ff,
	output reg                 bankSel_ff,
	output reg                 evtRequest_ff,
	output reg                 pulseWrapFlag_ff,
	output reg                 stampWrapFlag_ff,
	output reg                 stampWrapIrq_ff,
	output reg                 countHitFlag_ff,
	output reg                 countHitIrq_ff
);

////////////////////////////////////////////////////////////////////////////////

	// Returns {hit, index} for a 64-entry word array starting at base.
	function [6:0] arrDecode;
		input [`IEP_AW-1:0] addr;
		input [`IEP_AW-1:0] base;
		reg   [`IEP_AW-1:0] off;
		begin
			off       = addr - base;
			arrDecode = {(addr >= base) && (off[`IEP_AW-1:7] == 5'h00) &&
				!off[0], off[6:1]};
		end
	endfunction

	// Lowest pending channel, with a valid flag in the top bit.
	function [6:0] lowestSet;
		input [63:0] vec;
		integer      k;
		begin
			lowestSet = 7'h00;
			for (k = 63; k >= 0; k = k - 1)
				if (vec[k])
					lowestSet = {1'b1, k[5:0]};
		end
	endfunction

////////////////////////////////////////////////////////////////////////////////

	reg  [63:0]         syncA_ff;
	reg  [63:0]         syncB_ff;
	reg  [`IEP_DW-1:0]  cfg_ff [0:63];
	reg  [`IEP_DW-1:0]  pulseCnt_ff [0:63];
	reg  [9:0]          debCnt_ff [0:63];
	reg  [63:0]         wrapFlags_ff;
	reg  [63:0]         pending_ff;
	reg  [16:0]         preCnt_ff;
	reg  [`IEP_DW-1:0]  stamp_ff;
	reg  [`IEP_DW-1:0]  thresh_ff;
	reg  [`IEP_DW-1:0]  fill_ff;
	reg  [`IEP_DW-1:0]  index_ff;
	reg  [`IEP_DW-1:0]  nxt_fill;
	reg  [`IEP_DW-1:0]  rdMux;
	wire                msTick;
	wire [63:0]         accNow;
	wire [63:0]         edgeOk;
	wire [63:0]         cntStep;
	wire [6:0]          cfgHit;
	wire [6:0]          cntHit;
	wire [6:0]          pick;
	wire                wrReq;
	wire                wrapAny;
	reg                 wrapLow;
	reg  [63:0]         wrapSet;
	integer             i;
	integer             j;
	integer             m;

	assign msTick = (preCnt_ff == MS_CYCLES[16:0] - 17'h00001);
	assign cfgHit = arrDecode(hostAddr, `IEP_ADR_CFG_BASE);
	assign cntHit = arrDecode(hostAddr, `IEP_ADR_PCNT_BASE);
	assign pick   = lowestSet(pending_ff);
	assign wrReq  = hostWrEn && (hostAddr == `IEP_ADR_REQUEST);

////////////////////////////////////////////////////////////////////////////////

	// Per-channel acceptance. Alternating inputs arrive as pulse trains, so a
	// high sample is taken at once and only the fall waits out the window.
	genvar g;
	generate
		for (g = 0; g < 64; g = g + 1)
		begin : gChan
			wire [1:0] sel  = {cfg_ff[g][`IEP_EDGE_HI], cfg_ff[g][`IEP_EDGE_LO]};
			wire       ac   = cfg_ff[g][`IEP_AC_BIT];
			wire       away = ac ? ~syncB_ff[g] : syncB_ff[g] ^ chanLevel_ff[g];
			wire       done = away && msTick &&
				(debCnt_ff[g] == cfg_ff[g][`IEP_DEB_MSB:0]);
			assign accNow[g] = ac ? ((syncB_ff[g] & ~chanLevel_ff[g]) |
				(done & chanLevel_ff[g])) : done;
			assign edgeOk[g] = accNow[g] && (chanLevel_ff[g] ?
				sel[`IEP_EDGE_LO - `IEP_EDGE_LO] :
				sel[`IEP_EDGE_HI - `IEP_EDGE_LO]);
			assign cntStep[g] = edgeOk[g] && (sel != `IEP_EDGE_BOTH);
		end
	endgenerate

	assign wrapAny = |(cntStep & {
		pulseCnt_ff[63] == `IEP_MAX16, pulseCnt_ff[62] == `IEP_MAX16,
		pulseCnt_ff[61] == `IEP_MAX16, pulseCnt_ff[60] == `IEP_MAX16,
		60'h0}) | wrapLow;

	// Wrap detect for the remaining channels folded through a loop.
	// Each combinational loop owns its index so no two processes share
	// one variable, which would race in simulation.
	always @*
	begin
		wrapLow = 1'b0;
		for (j = 0; j < 60; j = j + 1)
			if (cntStep[j] && pulseCnt_ff[j] == `IEP_MAX16)
				wrapLow = 1'b1;
	end

////////////////////////////////////////////////////////////////////////////////

	// Synchroniser, debounce timers, levels, pulse counters and wrap flags.
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			syncA_ff     <= 64'h0;
			syncB_ff     <= 64'h0;
			chanLevel_ff <= 64'h0;
			cosStrobe_ff <= 64'h0;
			wrapFlags_ff <= 64'h0;
			for (i = 0; i < 64; i = i + 1)
			begin
				cfg_ff[i]      <= `IEP_CFG_RESET;
				pulseCnt_ff[i] <= `IEP_ZERO16;
				debCnt_ff[i]   <= 10'h000;
			end
		end
		else
		begin
			syncA_ff     <= chanIn;
			syncB_ff     <= syncA_ff;
			cosStrobe_ff <= edgeOk;
			for (i = 0; i < 64; i = i + 1)
			begin
				if (accNow[i])
				begin
					chanLevel_ff[i] <= ~chanLevel_ff[i];
					debCnt_ff[i]    <= 10'h000;
				end
				else if (!(cfg_ff[i][`IEP_AC_BIT] ? ~syncB_ff[i] :
					syncB_ff[i] ^ chanLevel_ff[i]))
					debCnt_ff[i] <= 10'h000;
				else if (msTick &&
					debCnt_ff[i] != cfg_ff[i][`IEP_DEB_MSB:0])
					debCnt_ff[i] <= debCnt_ff[i] + 10'h001;
				if (hostWrEn && cfgHit[6] && cfgHit[5:0] == i[5:0])
					cfg_ff[i] <= hostWrData;
				if (hostWrEn && cntHit[6] && cntHit[5:0] == i[5:0])
					pulseCnt_ff[i] <= hostWrData;
				else if (cntStep[i])
					pulseCnt_ff[i] <= pulseCnt_ff[i] + 16'h0001;
			end
			// A wrap in the same cycle as a clearing write still lands.
			wrapFlags_ff <= (wrapFlags_ff & ~(
				{hostWrEn && hostAddr == `IEP_ADR_WRAP0 ? ~hostWrData : 16'h0,
				 hostWrEn && hostAddr == `IEP_ADR_WRAP1 ? ~hostWrData : 16'h0,
				 hostWrEn && hostAddr == `IEP_ADR_WRAP2 ? ~hostWrData : 16'h0,
				 hostWrEn && hostAddr == `IEP_ADR_WRAP3 ? ~hostWrData : 16'h0}))
				| wrapSet;
		end
	end

	// A host load of the counter in the wrap cycle wins, so no wrap flag bit is
	// raised for a step that never happened; pulseWrapFlag_ff still pulses via wrapAny.
	always @*
	begin
		for (m = 0; m < 64; m = m + 1)
			wrapSet[m] = cntStep[m] && pulseCnt_ff[m] == `IEP_MAX16 &&
				!(hostWrEn && cntHit[6] && cntHit[5:0] == m[5:0]);
	end

////////////////////////////////////////////////////////////////////////////////

	// Fill count: a request copies then restarts; an event in that cycle
	// is the first of the new buffer.
	always @*
	begin
		if (wrReq)
			nxt_fill = `IEP_ZERO16;
		else if (hostWrEn && hostAddr == `IEP_ADR_FILL)
			nxt_fill = hostWrData;
		else
			nxt_fill = fill_ff;
		if (pick[6])
			nxt_fill = (nxt_fill == `IEP_FILL_WRAP) ? `IEP_ZERO16 :
				nxt_fill + 16'h0001;
	end

	// Stamp, events, counts and status pulses.
	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			preCnt_ff        <= 17'h00000;
			stamp_ff         <= `IEP_ZERO16;
			thresh_ff        <= `IEP_ZERO16;
			fill_ff          <= `IEP_ZERO16;
			index_ff         <= `IEP_ZERO16;
			pending_ff       <= 64'h0;
			evtValid_ff      <= 1'b0;
			evtStamp_ff      <= `IEP_ZERO16;
			evtInfo_ff       <= `IEP_ZERO16;
			bankSel_ff       <= 1'b0;
			evtRequest_ff    <= 1'b0;
			pulseWrapFlag_ff <= 1'b0;
			stampWrapFlag_ff <= 1'b0;
			stampWrapIrq_ff  <= 1'b0;
			countHitFlag_ff  <= 1'b0;
			countHitIrq_ff   <= 1'b0;
		end
		else
		begin
			preCnt_ff <= msTick ? 17'h00000 : preCnt_ff + 17'h00001;
			if (hostWrEn && hostAddr == `IEP_ADR_STAMP && !testMode)
				stamp_ff <= hostWrData;
			else if (msTick)
				stamp_ff <= stamp_ff + 16'h0001;
			stampWrapFlag_ff <= msTick && stamp_ff == `IEP_MAX16;
			stampWrapIrq_ff  <= msTick && stamp_ff == `IEP_MAX16 &&
				stampIrqEn;
			if (hostWrEn && hostAddr == `IEP_ADR_THRESH)
				thresh_ff <= hostWrData;
			pulseWrapFlag_ff <= wrapAny;
			// Simultaneous changes queue here and leave one per cycle.
			pending_ff <= (pending_ff & ~(pick[6] ? 64'h1 << pick[5:0] :
				64'h0)) | cosStrobe_ff;
			evtValid_ff <= pick[6];
			if (pick[6])
			begin
				evtStamp_ff <= stamp_ff;
				evtInfo_ff  <= {7'h00, chanLevel_ff[pick[5:0]],
					2'b00, pick[5:0]};
			end
			if (wrReq)
			begin
				index_ff   <= fill_ff;
				bankSel_ff <= ~bankSel_ff;
			end
			else if (hostWrEn && hostAddr == `IEP_ADR_INDEX)
				index_ff <= hostWrData;
			evtRequest_ff <= wrReq;
			fill_ff       <= nxt_fill;
			countHitFlag_ff <= pick[6] && nxt_fill == thresh_ff;
			countHitIrq_ff  <= pick[6] && nxt_fill == thresh_ff &&
				countIrqEn;
		end
	end

////////////////////////////////////////////////////////////////////////////////

	// Read path; unmapped locations read as zero.
	always @*
	begin
		rdMux = `IEP_ZERO16;
		if (cfgHit[6])
			rdMux = cfg_ff[cfgHit[5:0]];
		else if (cntHit[6])
			rdMux = pulseCnt_ff[cntHit[5:0]];
		else
			case (hostAddr)
				`IEP_ADR_WRAP0:  rdMux = wrapFlags_ff[63:48];
				`IEP_ADR_WRAP1:  rdMux = wrapFlags_ff[47:32];
				`IEP_ADR_WRAP2:  rdMux = wrapFlags_ff[31:16];
				`IEP_ADR_WRAP3:  rdMux = wrapFlags_ff[15:0];
				`IEP_ADR_STAMP:  rdMux = stamp_ff;
				`IEP_ADR_THRESH: rdMux = thresh_ff;
				`IEP_ADR_FILL:   rdMux = fill_ff;
				`IEP_ADR_INDEX:  rdMux = index_ff;
				default:         rdMux = `IEP_ZERO16;
			endcase
	end

	always @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			hostRdData_ff  <= `IEP_ZERO16;
			hostRdValid_ff <= 1'b0;
		end
		else
		begin
			hostRdValid_ff <= hostRdEn;
			if (hostRdEn)
				hostRdData_ff <= rdMux;
		end
	end

endmodule // iep_input_event_processor

`default_nettype wire

//--- rtl/iep_consts.vh
// Register offsets, field positions and timing constants of the input event processor.
`ifndef IEP_CONSTS_VH
`define IEP_CONSTS_VH

`define IEP_AW             12
`define IEP_DW             16
`define IEP_ADR_WRAP0      12'h018
`define IEP_ADR_WRAP1      12'h01a
`define IEP_ADR_WRAP2      12'h01c
`define IEP_ADR_WRAP3      12'h01e
`define IEP_ADR_CFG_BASE   12'h020
`define IEP_ADR_PCNT_BASE  12'h0a0
`define IEP_ADR_STAMP      12'h120
`define IEP_ADR_THRESH     12'h122
`define IEP_ADR_FILL       12'h124
`define IEP_ADR_INDEX      12'h126
`define IEP_ADR_REQUEST    12'h802

`define IEP_EDGE_HI        15
`define IEP_EDGE_LO        14
`define IEP_AC_BIT         13
`define IEP_DEB_MSB        9
`define IEP_EDGE_OFF       2'b00
`define IEP_EDGE_FALL      2'b01
`define IEP_EDGE_RISE      2'b10
`define IEP_EDGE_BOTH      2'b11

`define IEP_LVL_BIT        8
`define IEP_CFG_RESET      16'h0000
`define IEP_ZERO16         16'h0000
`define IEP_MAX16          16'hffff
`define IEP_FILL_WRAP      16'h0c00

`define IEP_CLK_NS         10
`define IEP_MS_NS          1000000

`endif

//--- tb/iep_properties.sv
// Checker of port timing relations for the input event processor.
`timescale 1ns/1ps
`default_nettype none
`include "iep_consts.vh"
module iep_properties #(
	parameter MS_CYCLES = 20
) (
	input wire logic               ref_clk,
	input wire logic               rst,
	input wire logic [`IEP_AW-1:0] hostAddr,
	input wire logic               hostWrEn,
	input wire logic               hostRdEn,
	input wire logic               hostRdValid_ff,
	input wire logic [63:0]        chanLevel_ff,
	input wire logic [63:0]        cosStrobe_ff,
	input wire logic               evtValid_ff,
	input wire logic [`IEP_DW-1:0] evtInfo_ff,
	input wire logic               bankSel_ff,
	input wire logic               evtRequest_ff,
	input wire logic               stampWrapFlag_ff,
	input wire logic               stampWrapIrq_ff,
	input wire logic               countHitFlag_ff,
	input wire logic               countHitIrq_ff
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_reqWr;
		hostWrEn && hostAddr == `IEP_ADR_REQUEST;
	endsequence
	sequence s_swap;
		evtRequest_ff && bankSel_ff != $past(bankSel_ff);
	endsequence
	property p_req;
		s_reqWr |=> s_swap;
	endproperty
	property p_reqOnly;
		evtRequest_ff |-> $past(hostWrEn && hostAddr == `IEP_ADR_REQUEST);
	endproperty
	property p_rdv;
		hostRdValid_ff == $past(hostRdEn);
	endproperty
	property p_stampIrq;
		stampWrapIrq_ff |-> stampWrapFlag_ff;
	endproperty
	property p_countIrq;
		countHitIrq_ff |-> countHitFlag_ff;
	endproperty
	property p_cos;
		|cosStrobe_ff |-> (cosStrobe_ff & ~(chanLevel_ff ^ $past(chanLevel_ff))) == 0;
	endproperty
	property p_evtFmt;
		evtValid_ff |-> evtInfo_ff[15:9] == 7'h0 && evtInfo_ff[7:6] == 2'h0
			&& evtInfo_ff[8] == chanLevel_ff[evtInfo_ff[5:0]];
	endproperty
	property p_stampFlag;
		stampWrapFlag_ff |=> !stampWrapFlag_ff;
	endproperty
	a_req: assert property (p_req)
		else $error("buffer request not answered");
	a_reqOnly: assert property (p_reqOnly)
		else $error("buffer request without a write");
	a_rdv: assert property (p_rdv)
		else $error("read valid misplaced");
	a_stampIrq: assert property (p_stampIrq)
		else $error("stamp interrupt without flag");
	a_countIrq: assert property (p_countIrq)
		else $error("count interrupt without flag");
	a_cos: assert property (p_cos)
		else $error("strobe without level change");
	a_evtFmt: assert property (p_evtFmt)
		else $error("event word layout wrong");
	a_stampFlag: assert property (p_stampFlag)
		else $error("stamp wrap flag too long");
endmodule // iep_properties
bind iep_input_event_processor iep_properties #(.MS_CYCLES(MS_CYCLES)) iep_properties_inst (
	.ref_clk, .rst, .hostAddr, .hostWrEn, .hostRdEn, .hostRdValid_ff,
	.chanLevel_ff, .cosStrobe_ff, .evtValid_ff, .evtInfo_ff, .bankSel_ff,
	.evtRequest_ff, .stampWrapFlag_ff, .stampWrapIrq_ff, .countHitFlag_ff,
	.countHitIrq_ff);
`default_nettype wire

//--- tb/iep_host_model.sv
// Host processor model making single register accesses.
`timescale 1ns/1ps
`default_nettype none
`include "iep_consts.vh"
module iep_host_model (
	input  wire logic [`IEP_DW-1:0] hostRdData_ff,
	input  wire logic               hostRdValid_ff,
	input  wire logic               ref_clk,
	output logic [`IEP_AW-1:0]      hostAddr,
	output logic [`IEP_DW-1:0]      hostWrData,
	output logic                    hostWrEn,
	output logic                    hostRdEn
);
	// Idle lines carry inverted values so a stale word never looks valid.
	initial
	begin
		hostAddr = 12'h000;
		hostWrData = 16'h0000;
		hostWrEn = 1'h0;
		hostRdEn = 1'h0;
	end
	task wr(input logic [11:0] a, input logic [15:0] d);
		@(negedge ref_clk);
		hostAddr = a;
		hostWrData = d;
		hostWrEn = 1'h1;
		@(negedge ref_clk);
		hostWrEn = 1'h0;
		hostAddr = ~a;
		hostWrData = ~d;
	endtask
	task rd(input logic [11:0] a, output logic [15:0] d);
		@(negedge ref_clk);
		hostAddr = a;
		hostRdEn = 1'h1;
		@(negedge ref_clk);
		hostRdEn = 1'h0;
		hostAddr = ~a;
		d = (hostRdValid_ff === 1'h1) ? hostRdData_ff : 16'hxxxx;
	endtask
endmodule // iep_host_model
`default_nettype wire

//--- tb/iep_input_event_processor_bench.sv
// Self-checking bench for the input event processor.
`timescale 1ns/1ps
`default_nettype none
`include "iep_consts.vh"
module iep_input_event_processor_bench;
	logic ref_clk = 1'h0, rst = 1'h1, testMode = 1'h0;
	logic stampIrqEn = 1'h1, countIrqEn = 1'h1;
	logic [63:0] chanIn = 64'h0, chanLevel_ff, cosStrobe_ff;
	logic [11:0] hostAddr;
	logic [15:0] hostWrData, hostRdData_ff, evtStamp_ff, evtInfo_ff, v;
	logic hostWrEn, hostRdEn, hostRdValid_ff, evtValid_ff, bankSel_ff;
	logic evtRequest_ff, pulseWrapFlag_ff, stampWrapFlag_ff, stampWrapIrq_ff;
	logic countHitFlag_ff, countHitIrq_ff;
	logic [15:0] evtCnt [64];
	logic [15:0] nPw = 16'h0, nSw = 16'h0, nSi = 16'h0, nCh = 16'h0, nCi = 16'h0;
	int num_errors = 0, n_compared = 0, n;
	// Rows: address, written word, word read back.
	logic [43:0] rows [6] = '{44'h020_2005_2005, 44'h09e_4013_4013,
		44'h0aa_1234_1234, 44'h122_0003_0003, 44'h128_0300_0000,
		44'h126_00aa_00aa};
	logic [15:0] evExp [4] = '{16'h0, 16'h1, 16'h1, 16'h2};
	logic [15:0] pcExp [4] = '{16'h0, 16'h0, 16'h1, 16'h0};
	always #5 ref_clk = ~ref_clk;
	iep_host_model iep_host_model_inst (.*);
	iep_input_event_processor #(.MS_CYCLES(20)) iep_input_event_processor_inst (.*);
	initial
		foreach (evtCnt[i]) evtCnt[i] = 16'h0;
	always @(posedge ref_clk)
	begin
		if (evtValid_ff === 1'h1) evtCnt[evtInfo_ff[5:0]] <= evtCnt[evtInfo_ff[5:0]] + 1;
		nPw <= nPw + pulseWrapFlag_ff;
		nSw <= nSw + stampWrapFlag_ff;
		nSi <= nSi + stampWrapIrq_ff;
		nCh <= nCh + countHitFlag_ff;
		nCi <= nCi + countHitIrq_ff;
	end
	task chk(input string w, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", w, e, g);
		end
	endtask
	task results;
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#50000;
		num_errors++;
		results;
	end
	initial
	begin
		repeat (16) @(negedge ref_clk);
		rst = 1'h0;
		iep_host_model_inst.rd(`IEP_ADR_FILL, v);
		chk("fill at reset", 16'h0000, v);
		iep_host_model_inst.rd(12'h026, v);
		chk("config at reset", 16'h0000, v);
		foreach (rows[i])
		begin
			iep_host_model_inst.wr(rows[i][43:32], rows[i][31:16]);
			iep_host_model_inst.rd(rows[i][43:32], v);
			chk("register", rows[i][15:0], v);
		end
		testMode = 1'h1;
		iep_host_model_inst.wr(`IEP_ADR_STAMP, 16'h5555);
		iep_host_model_inst.rd(`IEP_ADR_STAMP, v);
		chk("stamp preset in test", 16'h0, {15'h0, v == 16'h5555});
		// Single rising edge on channel 3 with its counter one step short of wrapping.
		iep_host_model_inst.wr(12'h026, 16'h8001);
		iep_host_model_inst.wr(12'h0a6, 16'hffff);
		chanIn[3] = 1'h1;
		repeat (120) @(negedge ref_clk);
		chk("ch3 events", 16'h1, evtCnt[3]);
		chk("event info", 16'h0103, evtInfo_ff);
		iep_host_model_inst.rd(`IEP_ADR_STAMP, v);
		chk("event stamp", 16'h1, {15'h0, (v - evtStamp_ff) < 16'h8});
		iep_host_model_inst.rd(12'h0a6, v);
		chk("ch3 counter", 16'h0000, v);
		iep_host_model_inst.rd(`IEP_ADR_WRAP3, v);
		chk("wrap low word", 16'h0008, v);
		chk("wrap status", 16'h1, nPw);
		iep_host_model_inst.wr(`IEP_ADR_WRAP3, 16'h0000);
		iep_host_model_inst.rd(`IEP_ADR_WRAP3, v);
		chk("wrap cleared", 16'h0000, v);
		// Every edge code, code i on channel 63-i; channel 62 wraps on its falling edge.
		for (int i = 0; i < 4; i++)
			iep_host_model_inst.wr(12'h09e - 12'(2 * i), {2'(i), 14'h0});
		iep_host_model_inst.wr(12'h11c, 16'hffff);
		chanIn[63:60] = 4'hf;
		repeat (120) @(negedge ref_clk);
		chanIn[63:60] = 4'h0;
		repeat (120) @(negedge ref_clk);
		for (int i = 0; i < 4; i++)
		begin
			chk("mode events", evExp[i], evtCnt[63 - i]);
			iep_host_model_inst.rd(12'h11e - 12'(2 * i), v);
			chk("mode counter", pcExp[i], v);
		end
		iep_host_model_inst.rd(`IEP_ADR_WRAP0, v);
		chk("wrap high word", 16'h4000, v);
		// A short glitch is ignored; a held level is taken after three ticks.
		iep_host_model_inst.wr(12'h048, 16'h8002);
		chanIn[20] = 1'h1;
		repeat (20) @(negedge ref_clk);
		chanIn[20] = 1'h0;
		repeat (100) @(negedge ref_clk);
		chk("glitch", 16'h0, evtCnt[20]);
		chanIn[20] = 1'h1;
		n = 0;
		while (cosStrobe_ff[20] !== 1'h1 && n < 200)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk("debounce time", 16'h1, {15'h0, n >= 40 && n <= 64});
		repeat (5) @(negedge ref_clk);
		chk("threshold hits", 16'h1, nCh);
		chk("threshold irq", 16'h1, nCi);
		iep_host_model_inst.rd(`IEP_ADR_FILL, v);
		chk("fill count", 16'h0006, v);
		iep_host_model_inst.wr(`IEP_ADR_REQUEST, 16'h1234);
		iep_host_model_inst.rd(`IEP_ADR_INDEX, v);
		chk("index", 16'h0006, v);
		iep_host_model_inst.rd(`IEP_ADR_FILL, v);
		chk("fill after request", 16'h0000, v);
		testMode = 1'h0;
		iep_host_model_inst.wr(`IEP_ADR_STAMP, 16'hfffe);
		iep_host_model_inst.rd(`IEP_ADR_STAMP, v);
		chk("stamp preset", 16'h1, {15'h0, v == 16'hfffe || v == 16'hffff});
		repeat (60) @(negedge ref_clk);
		chk("stamp wrap", 16'h1, nSw);
		chk("stamp irq", 16'h1, nSi);
		results;
	end
endmodule // iep_input_event_processor_bench
`default_nettype wire
